// ===== verilog/iex_top.v
// Input expander: address decode, pullup select, change detect, I2C slave
// Function
// RULE_01: The address is re-judged on every bus transmission, whoever it addresses.
// RULE_02: Each select pin is classed as high, low, tied to the data line or tied to the clock line.
// RULE_03: Before the first transmission a pin on the data or clock line counts as high.
// RULE_04: Address top bits are 110 and bits 3:2 come from the high pin as clock 00, data 01, low 10, high 11.
// RULE_05: Address bits 1:0 come from the low pin as low 00, high 01, clock 10, data 11.
// RULE_06: Pullups of ports 0-3 follow the low pin and of ports 4-7 the high pin.
// RULE_07: A group is pulled up unless its pin is tied low.
// RULE_08: The pullup choice is refreshed from the full decode at the first transmission.
// RULE_09: A snapshot register holds all eight inputs as the change reference.
// RULE_10: Any input differing from the snapshot sets its transition flag.
// RULE_11: At every access acknowledge the inputs go to the snapshot and the flags clear.
// RULE_12: A two-byte read returns port data then the flags as they were before clearing.
// RULE_13: A read may go on past two bytes and the device keeps sending bytes.
// RULE_14: A flag stays set though the input returns, until the next access.
// RULE_15: Long reads alternate fresh port data with flag bytes, resetting flags each time.
// RULE_16: Inputs are synchronised before comparison with the snapshot.
// RULE_17: Reset loads the snapshot, clears flags and sets the power-up address assumption.
//
// Decided for this implementation: the plain strobed port and the address map.
`include "iex_defines.vh"
module iex_top (
	input wire ref_clk,
	input wire reset_n,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire addr_sel_low_pin,
	input wire addr_sel_high_pin,
	input wire [7:0] input_ports,
	output wire [7:0] pullup_en,
	output wire [6:0] slave_addr,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output wire irq
);
	wire [7:0] in_s;
	wire scl_s;
	wire sda_s;
	wire lo_s;
	wire hi_s;
	// Every port input, bus line and select pin level passes two flops before use
	iex_sync2 #(.W(12)) u_sync (
		.clk(ref_clk),
		.rst_n(reset_n),
		.d({input_ports, scl_in, sda_in, addr_sel_low_pin, addr_sel_high_pin}),
		.q({in_s, scl_s, sda_s, lo_s, hi_s})
	); // [RULE_16]

	// Sync pipe shows reset zeros for two edges: edge finding and the snapshot wait for real levels
	reg [1:0] init_cnt_reg;
	wire sync_ok = (init_cnt_reg == 2'h3);
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			init_cnt_reg <= 2'h0;
		end else if (!sync_ok) begin
			init_cnt_reg <= init_cnt_reg + 2'h1;
		end
	end

	reg scl_d_reg;
	reg sda_d_reg;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	wire scl_rise = scl_s & ~scl_d_reg & sync_ok;
	wire scl_fall = ~scl_s & scl_d_reg & sync_ok;
	wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s & sync_ok;
	wire stop_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s & sync_ok;

	// Pin classing: track whether each pin follows the bus lines or sits at one level
	reg lo_hi_reg;
	reg lo_lo_reg;
	reg lo_nsda_reg;
	reg lo_nscl_reg;
	reg hi_hi_reg;
	reg hi_lo_reg;
	reg hi_nsda_reg;
	reg hi_nscl_reg;
	reg [1:0] lo_con_reg;
	reg [1:0] hi_con_reg;
	reg busy_reg;
	function [1:0] iex_class;
		input seen_hi, seen_lo, ne_sda, ne_scl;
		begin
			if (seen_hi && seen_lo)
				iex_class = !ne_sda ? `IEX_CON_SDA : (!ne_scl ? `IEX_CON_SCL : `IEX_CON_HIGH);
			else if (seen_lo)
				iex_class = `IEX_CON_LOW;
			else
				iex_class = `IEX_CON_HIGH;
		end
	endfunction
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lo_hi_reg <= 1'b0;
			lo_lo_reg <= 1'b0;
			lo_nsda_reg <= 1'b0;
			lo_nscl_reg <= 1'b0;
			hi_hi_reg <= 1'b0;
			hi_lo_reg <= 1'b0;
			hi_nsda_reg <= 1'b0;
			hi_nscl_reg <= 1'b0;
			lo_con_reg <= `IEX_CON_HIGH; // [RULE_03] [RULE_17]
			hi_con_reg <= `IEX_CON_HIGH;
			busy_reg <= 1'b0;
		end else if (start_c) begin
			busy_reg <= 1'b1;
			lo_hi_reg <= lo_s;
			lo_lo_reg <= ~lo_s;
			lo_nsda_reg <= 1'b0;
			lo_nscl_reg <= 1'b0;
			hi_hi_reg <= hi_s;
			hi_lo_reg <= ~hi_s;
			hi_nsda_reg <= 1'b0;
			hi_nscl_reg <= 1'b0;
		end else if (stop_c && busy_reg) begin
			// Decode settles at the end of each transmission, any target [RULE_01] [RULE_08]
			busy_reg <= 1'b0;
			lo_con_reg <= iex_class(lo_hi_reg, lo_lo_reg, lo_nsda_reg, lo_nscl_reg); // [RULE_02]
			hi_con_reg <= iex_class(hi_hi_reg, hi_lo_reg, hi_nsda_reg, hi_nscl_reg);
		end else if (busy_reg) begin
			lo_hi_reg <= lo_hi_reg | lo_s;
			lo_lo_reg <= lo_lo_reg | ~lo_s;
			lo_nsda_reg <= lo_nsda_reg | (lo_s ^ sda_s);
			lo_nscl_reg <= lo_nscl_reg | (lo_s ^ scl_s);
			hi_hi_reg <= hi_hi_reg | hi_s;
			hi_lo_reg <= hi_lo_reg | ~hi_s;
			hi_nsda_reg <= hi_nsda_reg | (hi_s ^ sda_s);
			hi_nscl_reg <= hi_nscl_reg | (hi_s ^ scl_s);
		end
	end
	reg [1:0] a32;
	reg [1:0] a10;
	always @* begin
		case (hi_con_reg) // [RULE_04]
			`IEX_CON_SCL: a32 = 2'h0;
			`IEX_CON_SDA: a32 = 2'h1;
			`IEX_CON_LOW: a32 = 2'h2;
			default: a32 = 2'h3;
		endcase
		case (lo_con_reg) // [RULE_05]
			`IEX_CON_LOW: a10 = 2'h0;
			`IEX_CON_HIGH: a10 = 2'h1;
			`IEX_CON_SCL: a10 = 2'h2;
			default: a10 = 2'h3;
		endcase
	end
	assign slave_addr = {`IEX_ADDR_TOP, a32, a10};
	assign pullup_en = {{4{hi_con_reg != `IEX_CON_LOW}}, {4{lo_con_reg != `IEX_CON_LOW}}}; // [RULE_06] [RULE_07]

	// I2C slave
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_WR = 3'h3;
	localparam ST_WACK = 3'h4;
	localparam ST_RD = 3'h5;
	localparam ST_RACK = 3'h6;
	reg [2:0] st_reg;
	reg [3:0] bit_reg;
	reg [7:0] sh_reg;
	reg rw_reg;
	reg flag_phase_reg;
	reg [7:0] snap_reg;
	reg [7:0] flags_reg;
	reg [7:0] flags_held_reg;
	reg [7:0] mask_reg;
	reg [7:0] status_reg;
	wire addr_hit = (sh_reg[7:1] == slave_addr);
	// Ack pulse of an access: our address ack or a write-data ack
	wire acc_ack = scl_rise && (st_reg == ST_AACK || st_reg == ST_WACK);
	wire [7:0] diff = (in_s ^ snap_reg) & {8{sync_ok}};
	wire [7:0] tx_byte = flag_phase_reg ? flags_held_reg : snap_reg; // [RULE_12]

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			rw_reg <= 1'b0;
			flag_phase_reg <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start_c) begin
			st_reg <= ST_ADDR;
			bit_reg <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			st_reg <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (st_reg)
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						sh_reg <= {sh_reg[6:0], sda_s};
						bit_reg <= bit_reg + 4'h1;
					end else if (scl_fall && bit_reg == 4'h8) begin
						bit_reg <= 4'h0;
						if (st_reg == ST_WR) begin
							st_reg <= ST_WACK;
							sda_oe <= 1'b1;
						end else if (addr_hit) begin
							rw_reg <= sh_reg[0];
							st_reg <= ST_AACK;
							sda_oe <= 1'b1;
						end else
							st_reg <= ST_IDLE;
					end
				end
				ST_AACK, ST_WACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							st_reg <= ST_RD;
							flag_phase_reg <= 1'b0;
							sda_oe <= ~snap_reg[7];
						end else begin
							st_reg <= ST_WR;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (bit_reg == 4'h7) begin
							bit_reg <= 4'h0;
							st_reg <= ST_RACK;
							sda_oe <= 1'b0;
						end else begin
							bit_reg <= bit_reg + 4'h1;
							sda_oe <= ~tx_byte[3'h6 - bit_reg[2:0]];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						if (sda_s)
							st_reg <= ST_IDLE;
					end else if (scl_fall) begin
						// Master acked: keep streaming, alternate data and flags [RULE_13] [RULE_15]
						st_reg <= ST_RD;
						flag_phase_reg <= ~flag_phase_reg;
						// First bit from the copy tx_byte shifts: snap_reg resampled at this ack, or flags_held_reg latched at the ack before the data byte
						sda_oe <= ~(flag_phase_reg ? snap_reg[7] : flags_held_reg[7]);
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	// Resample at master ack ahead of each port data byte after the first in a long read
	wire rd_resample = scl_rise && st_reg == ST_RACK && !sda_s && flag_phase_reg;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			snap_reg <= 8'h00;
			flags_reg <= 8'h00; // [RULE_17]
			flags_held_reg <= 8'h00;
		end else if (!sync_ok) begin
			// Keep loading until the sync pipe carries real levels
			snap_reg <= in_s; // [RULE_17]
		end else if (acc_ack || rd_resample) begin
			snap_reg <= in_s; // [RULE_09] [RULE_11]
			flags_held_reg <= flags_reg | diff; // [RULE_12]
			flags_reg <= 8'h00; // [RULE_11] [RULE_15]
		end else
			flags_reg <= flags_reg | diff; // [RULE_10] [RULE_14]
	end

	// Interrupt status: sticky change events, write one to clear, set wins
	wire [7:0] st_clr = (reg_wr && reg_addr == `IEX_REG_STATUS) ? reg_wdata : 8'h00;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_reg <= 8'h00;
			mask_reg <= `IEX_MASK_RST;
			reg_rdata <= 8'h00;
		end else begin
			status_reg <= (status_reg & ~st_clr) | diff;
			if (reg_wr && reg_addr == `IEX_REG_MASK)
				mask_reg <= reg_wdata;
			if (reg_rd) begin
				case (reg_addr)
					`IEX_REG_STATUS: reg_rdata <= status_reg;
					`IEX_REG_MASK: reg_rdata <= mask_reg;
					`IEX_REG_SNAP: reg_rdata <= snap_reg;
					default: reg_rdata <= {1'b0, slave_addr};
				endcase
			end else
				reg_rdata <= 8'h00;
		end
	end
	assign irq = |(status_reg & mask_reg);
endmodule

// ===== inc/iex_defines.vh
// Constants for the input expander address and change-detect block
`ifndef IEX_DEFINES_VH
`define IEX_DEFINES_VH
`define IEX_ADDR_TOP 3'h6
`define IEX_CON_SCL 2'h0
`define IEX_CON_SDA 2'h1
`define IEX_CON_LOW 2'h2
`define IEX_CON_HIGH 2'h3
`define IEX_REG_STATUS 2'h0
`define IEX_REG_MASK 2'h1
`define IEX_REG_SNAP 2'h2
`define IEX_REG_ADDR 2'h3
`define IEX_MASK_RST 8'hFF
`endif

// ===== verilog/iex_sync2.v
// Two-flop synchroniser for a bus of pins
module iex_sync2 #(
	parameter W = 8
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ===== dv/iex_chk.sv
// Port checker for the input expander
module iex_chk (
	input wire ref_clk,
	input wire reset_n,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire [7:0] pullup_en,
	input wire [6:0] slave_addr,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	chk_addr_top: assert property (slave_addr[6:4] == 3'h6) else $error("address top bits");
	chk_low_group: assert property (pullup_en[3:0] == {4{slave_addr[1:0] != 2'h0}})
		else $error("low pullup group");
	chk_high_group: assert property (pullup_en[7:4] == {4{slave_addr[3:2] != 2'h2}})
		else $error("high pullup group");
	chk_addr_at_stop: assert property (!$stable(slave_addr) |-> scl_in && sda_in)
		else $error("address moved mid frame");
	chk_sda_drain: assert property (sda_out == 1'h0) else $error("data line driven high");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
	chk_mask_off: assert property (reg_wr && reg_addr == 2'h1 && reg_wdata == 8'h00 |=> !irq)
		else $error("masked irq high");
	chk_low_hold: assert property ($rose(sda_oe) |-> sda_oe [*4]) else $error("line pull too short");
endmodule
bind iex_top iex_chk u_chk (.*);

// ===== dv/iex_mst.sv
// Bus master model making the link clock
module iex_mst (
	output logic scl,
	output logic sda_low,
	input wire sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] rx;
	event rx_ev;
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end
	// Data moves only while the clock is low
	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		#50 scl = 1'h1;
		#50 r = sda;
		#50 scl = 1'h0;
		#50;
	endtask
	task automatic start;
		sda_low = 1'h1;
		#100 scl = 1'h0;
	endtask
	task automatic stop;
		sda_low = 1'h1;
		#50 scl = 1'h1;
		#100 sda_low = 1'h0;
		#100;
	endtask
	// Reads go on for as many bytes as the caller asks
	task automatic xfer(input logic [7:0] d, input logic m);
		for (int i = 8; i >= 0; i--)
			bitx(i ? d[i-1] : m, rx[i]);
		-> rx_ev;
	endtask
endmodule

// ===== dv/iex_top_test.sv
// Testbench for the input expander
module iex_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, reset_n, reg_wr, reg_rd, rd_d, sda_out, sda_oe, irq, scl, sda_low;
	logic [1:0] reg_addr, hm, lm;
	logic [7:0] reg_wdata, input_ports, p0, reg_rdata, pullup_en;
	logic [6:0] slave_addr;
	wire sda = !(sda_oe || sda_low);
	wire ah = hm == 2'h0 ? scl : hm == 2'h1 ? sda : hm[0];
	wire al = lm == 2'h0 ? scl : lm == 2'h1 ? sda : lm[0];
	int num_errors, num_checks, seed = 32'h77727979;
	logic [8:0] iq[$];
	logic [7:0] rq[$];
	iex_mst m (.scl(scl), .sda_low(sda_low), .sda(sda));
	iex_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_sel_low_pin(al), .addr_sel_high_pin(ah), .input_ports(input_ports),
		.pullup_en(pullup_en), .slave_addr(slave_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic bus(input logic [1:0] a, input logic [7:0] d, input logic w);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(a, 8'h00, 1'h0);
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = !ref_clk;
	end
	// Monitors take the oldest note whenever a result shows
	always @(posedge ref_clk) begin
		if (rd_d === 1'h1) check(reg_rdata, rq.pop_front());
		rd_d <= reg_rd;
	end
	always @(m.rx_ev) check(m.rx, iq.pop_front());
	initial begin
		#200000;
		num_errors++;
		stop_test;
	end
	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, hm, lm} = 17'h00001;
		p0 = 8'($random(seed));
		input_ports = p0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'h1;
		repeat (4) @(posedge ref_clk);
		check(pullup_en, 8'hFF);
		rd(2'h3, 8'h6D);
		rd(2'h2, p0);
		for (int i = 0; i < 16; i++) begin
			{hm, lm} <= i[3:0];
			m.start;
			iq.push_back(9'h041);
			m.xfer(8'h20, 1'h1);
			m.stop;
			repeat (8) @(posedge ref_clk);
			check(pullup_en, {{4{hm != 2'h2}}, {4{lm != 2'h2}}});
			rd(2'h3, {1'h0, 3'h6, hm, lm ^ 2'h2});
		end
		input_ports <= p0 ^ 8'h01;
		repeat (4) @(posedge ref_clk);
		input_ports <= p0 ^ 8'h30;
		repeat (4) @(posedge ref_clk);
		check(irq, 1'h1);
		rd(2'h0, 8'h31);
		bus(2'h1, 8'h00, 1'h1);
		@(negedge ref_clk);
		check(irq, 1'h0);
		bus(2'h1, 8'hFF, 1'h1);
		m.start;
		iq.push_back({8'hDB, 1'h0});
		m.xfer(8'hDB, 1'h1);
		iq.push_back({p0 ^ 8'h30, 1'h0});
		m.xfer(8'hFF, 1'h0);
		@(posedge ref_clk) input_ports <= p0 ^ 8'h34;
		iq.push_back({8'h31, 1'h0});
		m.xfer(8'hFF, 1'h0);
		iq.push_back({p0 ^ 8'h34, 1'h1});
		m.xfer(8'hFF, 1'h1);
		m.stop;
		rd(2'h2, p0 ^ 8'h34);
		@(posedge ref_clk) input_ports <= p0 ^ 8'hB4;
		repeat (4) @(posedge ref_clk);
		m.start;
		iq.push_back({8'hDA, 1'h0});
		m.xfer(8'hDA, 1'h1);
		iq.push_back({8'h5A, 1'h0});
		m.xfer(8'h5A, 1'h1);
		m.stop;
		rd(2'h2, p0 ^ 8'hB4);
		bus(2'h0, 8'hFF, 1'h1);
		@(negedge ref_clk);
		check(irq, 1'h0);
		repeat (2) @(posedge ref_clk);
		stop_test;
	end
endmodule
